/* File: include/res_pkg.sv */
// Shared constants and types for the ring event suppression block
package res_pkg;

  // ----------------------------------------------------------------
  // APB register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_QSIZE      = 12'h004;
  localparam logic [11:0] REG_AVAIL_BASE = 12'h008;
  localparam logic [11:0] REG_USED_BASE  = 12'h00C;
  localparam logic [11:0] REG_STATUS     = 12'h010;
  localparam logic [11:0] REG_SEEN       = 12'h014;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_EVT_BIT   = 1;
  localparam int          CTRL_SUP_BIT   = 2;
  localparam int          CTRL_KICK_BIT  = 3;
  localparam logic [2:0]  CTRL_RST       = 3'h0;
  localparam logic [15:0] QSIZE_RST      = 16'h0100;
  localparam logic [31:0] BASE_RST       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Ring layout in memory, byte offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] RING_FLAGS_OFS = 32'h0000_0000;
  localparam logic [31:0] RING_IDX_OFS   = 32'h0000_0002;
  localparam logic [31:0] RING_ENT_OFS   = 32'h0000_0004;
  localparam logic [31:0] USED_LEN_OFS   = 32'h0000_0004;
  localparam logic [1:0]  AVAIL_SHIFT    = 2'h1;
  localparam logic [1:0]  USED_SHIFT     = 2'h3;
  localparam int          FLAG_SUP_BIT   = 0;
  localparam logic [15:0] CNT_RST        = 16'h0000;

  // ----------------------------------------------------------------
  // Descriptor flag positions
  // ----------------------------------------------------------------
  localparam int          DESC_WRITE_BIT = 1;
  localparam int          DESC_IND_BIT   = 2;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_RD_AIDX = 4'h1,
    S_RD_ENT  = 4'h2,
    S_WR_ID   = 4'h3,
    S_WR_LEN  = 4'h4,
    S_WR_UIDX = 4'h5,
    S_RD_AFLG = 4'h6,
    S_RD_UEVT = 4'h7,
    S_DECIDE  = 4'h8,
    S_WR_UFLG = 4'h9,
    S_WR_AEVT = 4'hA
  } res_state_t;

  // Address of a ring slot or of the trailing field
  function automatic logic [31:0] res_ring_addr(input logic [31:0] base,
                                                input logic [15:0] slot,
                                                input logic [1:0]  shift);
    return base + RING_ENT_OFS + ({16'h0000, slot} << shift);
  endfunction : res_ring_addr

  // Halfword write lanes from the byte address
  function automatic logic [3:0] res_half_be(input logic [31:0] addr);
    return addr[1] ? 4'hC : 4'h3;
  endfunction : res_half_be

endpackage : res_pkg

/* File: include/res_sup_if.sv */
// Link between the ring sequencer and the suppression decision unit
`timescale 1ns/100ps
interface res_sup_if;
  logic        evt;
  logic        suppress;
  logic [15:0] avail_flags;
  logic [15:0] used_event;
  logic [15:0] old_idx;
  logic [15:0] last_avail;
  logic        need;
  logic [15:0] used_flags;
  logic [15:0] avail_event;

  modport core (output evt, suppress, avail_flags, used_event, old_idx, last_avail,
                input  need, used_flags, avail_event);
  modport sup  (input  evt, suppress, avail_flags, used_event, old_idx, last_avail,
                output need, used_flags, avail_event);
endinterface : res_sup_if

/* File: verilog/res_sup.sv */
// Interrupt decision and published suppression values
`timescale 1ns/100ps
module res_sup (
  input  wire logic pclk,
  input  wire logic presetn,
  res_sup_if.sup    sif
);

  // ----------------------------------------------------------------
  // Decision
  // ----------------------------------------------------------------
  wire legacy_need = ~sif.avail_flags[res_pkg::FLAG_SUP_BIT];
  wire evt_need    = (sif.old_idx == sif.used_event);

  assign sif.need        = sif.evt ? evt_need : legacy_need;
  assign sif.used_flags  = sif.evt ? 16'h0000 : {15'h0000, sif.suppress};
  assign sif.avail_event = sif.suppress ? sif.last_avail - 16'h0001 : sif.last_avail;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_EVT_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
    sif.evt && (sif.old_idx == sif.used_event) |-> sif.need)
    else $error("threshold match gave no interrupt");
  AST_EVT_LOWBIT: assert property (@(posedge pclk) disable iff (!presetn)
    sif.evt && (sif.old_idx != sif.used_event) |-> !sif.need)
    else $error("flags bit used with event index");
  AST_LEGACY: assert property (@(posedge pclk) disable iff (!presetn)
    !sif.evt |-> (sif.need != sif.avail_flags[0]))
    else $error("legacy flags decision wrong");
  AST_FLAGS_VAL: assert property (@(posedge pclk) disable iff (!presetn)
    sif.used_flags[15:1] == 15'h0000 && (!sif.evt || sif.used_flags == 16'h0000))
    else $error("published flags out of range");

endmodule : res_sup

/* File: verilog/res_core.sv */
// Ring sequencer with APB registers and memory master port
//
// What this block does
// - Indirect descriptors never report device-writable
// - Offered ring is only read here
// - Offered counter starts at zero, increments
// - Legacy: interrupt when offered flags zero
// - Event index: ignore offered flags bit
// - Event index: interrupt when counter equals threshold
// - Threshold compare wraps at 16 bits
// - Completed ring layout flags, counter, entries, threshold
// - Completed ring is only written here
// - Entry words are head index, length
// - Legacy: published flags only 0/1
// - Event index: flags zero, publish threshold
// - Spurious notifications cause no malfunction
// - Counters compare modulo 65536
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module res_core #(
  parameter int PADDR_W = 12
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    mem_req,
  output logic                    mem_we,
  output logic [31:0]             mem_addr,
  output logic [31:0]             mem_wdata,
  output logic [3:0]              mem_be,
  input  wire logic               mem_ack,
  input  wire logic [31:0]        mem_rdata,
  input  wire logic               notify,
  input  wire logic               done_valid,
  input  wire logic [15:0]        done_id,
  input  wire logic [31:0]        done_len,
  output logic                    done_ready,
  output logic                    head_valid,
  output logic [15:0]             head_id,
  input  wire logic               head_ready,
  input  wire logic [15:0]        desc_flags,
  output logic                    desc_writable,
  output logic                    irq
);

  if (PADDR_W < 5 || PADDR_W > 32) begin : g_chk
    $error("PADDR_W must lie between 5 and 32");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  res_pkg::res_state_t state_r, state_nxt;
  logic [2:0]  ctrl_r;
  logic [15:0] qsize_r;
  logic [31:0] abase_r, ubase_r;
  logic [15:0] last_avail_r, avail_idx_r, avail_flags_r, used_event_r;
  logic [15:0] used_idx_r, old_idx_r, cmp_id_r, head_r;
  logic [31:0] cmp_len_r, prdata_r, maddr_r, mwdata_r;
  logic [3:0]  mbe_r;
  logic        cmp_pend_r, poll_pend_r, pready_r, pslverr_r, mreq_r, mwe_r, half_r;
  logic        done_ready_r, head_valid_r, desc_wr_r, irq_r;

  res_sup_if sif ();
  res_sup u_sup (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [11:0] rofs      = 12'(32'(paddr));
  wire        apb_setup = psel & ~penable;
  wire        apb_wr    = psel & penable & pready_r & pwrite;
  wire        hit_ctrl  = (rofs == res_pkg::REG_CTRL);
  wire        hit_qsz   = (rofs == res_pkg::REG_QSIZE);
  wire        hit_ab    = (rofs == res_pkg::REG_AVAIL_BASE);
  wire        hit_ub    = (rofs == res_pkg::REG_USED_BASE);
  wire        hit_st    = (rofs == res_pkg::REG_STATUS);
  wire        hit_seen  = (rofs == res_pkg::REG_SEEN);
  wire        hit_any   = hit_ctrl | hit_qsz | hit_ab | hit_ub | hit_st | hit_seen;
  wire [31:0] rd_mux    = hit_ctrl ? {29'h0, ctrl_r} :
                          hit_qsz  ? {16'h0000, qsize_r} :
                          hit_ab   ? abase_r :
                          hit_ub   ? ubase_r :
                          hit_st   ? {used_idx_r, last_avail_r} :
                          hit_seen ? {used_event_r, avail_idx_r} : 32'h0000_0000;
  wire        kick      = apb_wr & hit_ctrl & pwdata[res_pkg::CTRL_KICK_BIT];

  wire en  = ctrl_r[res_pkg::CTRL_EN_BIT];
  wire evt = ctrl_r[res_pkg::CTRL_EVT_BIT];

  // ----------------------------------------------------------------
  // Ring addresses
  // ----------------------------------------------------------------
  wire [15:0] qmask     = qsize_r - 16'h0001;
  wire [15:0] aslot     = last_avail_r & qmask;
  wire [15:0] uslot     = used_idx_r & qmask;
  wire [31:0] a_ent     = res_pkg::res_ring_addr(abase_r, aslot, res_pkg::AVAIL_SHIFT);
  wire [31:0] a_uevt    = res_pkg::res_ring_addr(abase_r, qsize_r, res_pkg::AVAIL_SHIFT);
  wire [31:0] u_id      = res_pkg::res_ring_addr(ubase_r, uslot, res_pkg::USED_SHIFT);
  wire [31:0] u_len     = u_id + res_pkg::USED_LEN_OFS;
  wire [31:0] u_aevt    = res_pkg::res_ring_addr(ubase_r, qsize_r, res_pkg::USED_SHIFT);
  wire [31:0] u_idx     = ubase_r + res_pkg::RING_IDX_OFS;
  wire [31:0] u_flg     = ubase_r + res_pkg::RING_FLAGS_OFS;
  wire [31:0] a_hdr     = abase_r + res_pkg::RING_FLAGS_OFS;
  wire [15:0] uidx_inc  = used_idx_r + 16'h0001;

  wire mem_st = (state_r != res_pkg::S_IDLE) && (state_r != res_pkg::S_DECIDE);
  wire wr_st  = (state_r == res_pkg::S_WR_ID) || (state_r == res_pkg::S_WR_LEN) ||
                (state_r == res_pkg::S_WR_UIDX) || (state_r == res_pkg::S_WR_UFLG) ||
                (state_r == res_pkg::S_WR_AEVT);
  wire [31:0] cur_addr  = (state_r == res_pkg::S_RD_ENT)  ? a_ent  :
                          (state_r == res_pkg::S_RD_UEVT) ? a_uevt :
                          (state_r == res_pkg::S_WR_ID)   ? u_id   :
                          (state_r == res_pkg::S_WR_LEN)  ? u_len  :
                          (state_r == res_pkg::S_WR_UIDX) ? u_idx  :
                          (state_r == res_pkg::S_WR_UFLG) ? u_flg  :
                          (state_r == res_pkg::S_WR_AEVT) ? u_aevt : a_hdr;
  wire [31:0] cur_wdata = (state_r == res_pkg::S_WR_ID)   ? {16'h0000, cmp_id_r} :
                          (state_r == res_pkg::S_WR_LEN)  ? cmp_len_r :
                          (state_r == res_pkg::S_WR_UIDX) ? {uidx_inc, uidx_inc} :
                          (state_r == res_pkg::S_WR_UFLG) ? {sif.used_flags, sif.used_flags} :
                          {sif.avail_event, sif.avail_event};
  wire [3:0]  cur_be    = ((state_r == res_pkg::S_WR_ID) || (state_r == res_pkg::S_WR_LEN)) ?
                          4'hF : res_pkg::res_half_be(cur_addr);
  wire [15:0] rd_half   = half_r ? mem_rdata[31:16] : mem_rdata[15:0];
  wire        ack       = mreq_r & mem_ack;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      res_pkg::S_IDLE: begin
        if (en && cmp_pend_r) begin
          state_nxt = res_pkg::S_WR_ID;
        end else if (en && (last_avail_r != avail_idx_r) && !head_valid_r) begin
          state_nxt = res_pkg::S_RD_ENT;
        end else if (en && poll_pend_r) begin
          state_nxt = res_pkg::S_RD_AIDX;
        end
      end
      res_pkg::S_RD_AIDX: if (ack) state_nxt = res_pkg::S_WR_UFLG;
      res_pkg::S_RD_ENT:  if (ack) state_nxt = res_pkg::S_IDLE;
      res_pkg::S_WR_ID:   if (ack) state_nxt = res_pkg::S_WR_LEN;
      res_pkg::S_WR_LEN:  if (ack) state_nxt = res_pkg::S_WR_UIDX;
      res_pkg::S_WR_UIDX: if (ack) state_nxt = res_pkg::S_RD_AFLG;
      res_pkg::S_RD_AFLG: if (ack) state_nxt = evt ? res_pkg::S_RD_UEVT : res_pkg::S_DECIDE;
      res_pkg::S_RD_UEVT: if (ack) state_nxt = res_pkg::S_DECIDE;
      res_pkg::S_DECIDE:  state_nxt = res_pkg::S_WR_UFLG;
      res_pkg::S_WR_UFLG: if (ack) state_nxt = evt ? res_pkg::S_WR_AEVT : res_pkg::S_IDLE;
      res_pkg::S_WR_AEVT: if (ack) state_nxt = res_pkg::S_IDLE;
      default:            state_nxt = res_pkg::S_IDLE;
    endcase
  end

  wire rd_hdr     = ack && ((state_r == res_pkg::S_RD_AIDX) || (state_r == res_pkg::S_RD_AFLG));
  wire take_done  = en && (state_r == res_pkg::S_IDLE) && done_valid && !cmp_pend_r && !done_ready_r;
  wire cnt_clr    = !en && (state_r == res_pkg::S_IDLE);
  wire poll_set   = notify | kick;
  wire poll_clr   = ack && (state_r == res_pkg::S_RD_AIDX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= res_pkg::S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // APB slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup & ~hit_any;
      prdata_r  <= (apb_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= res_pkg::CTRL_RST;
      qsize_r <= res_pkg::QSIZE_RST;
      abase_r <= res_pkg::BASE_RST;
      ubase_r <= res_pkg::BASE_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) ctrl_r  <= pwdata[2:0];
      if (hit_qsz)  qsize_r <= pwdata[15:0];
      if (hit_ab)   abase_r <= pwdata;
      if (hit_ub)   ubase_r <= pwdata;
    end
  end

  // Memory master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mreq_r   <= 1'b0;
      mwe_r    <= 1'b0;
      maddr_r  <= 32'h0000_0000;
      mwdata_r <= 32'h0000_0000;
      mbe_r    <= 4'h0;
      half_r   <= 1'b0;
    end else begin
      mreq_r   <= mem_st & ~mem_ack;
      mwe_r    <= wr_st;
      maddr_r  <= {cur_addr[31:2], 2'b00};
      mwdata_r <= cur_wdata;
      mbe_r    <= cur_be;
      half_r   <= cur_addr[1];
    end
  end

  // Counters and captured ring fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_avail_r  <= res_pkg::CNT_RST;
      avail_idx_r   <= res_pkg::CNT_RST;
      avail_flags_r <= res_pkg::CNT_RST;
      used_event_r  <= res_pkg::CNT_RST;
      used_idx_r    <= res_pkg::CNT_RST;
      old_idx_r     <= res_pkg::CNT_RST;
      head_r        <= res_pkg::CNT_RST;
    end else if (cnt_clr) begin
      last_avail_r  <= res_pkg::CNT_RST;
      avail_idx_r   <= res_pkg::CNT_RST;
      used_idx_r    <= res_pkg::CNT_RST;
    end else begin
      if (rd_hdr) avail_flags_r <= mem_rdata[15:0];
      if (rd_hdr) avail_idx_r   <= mem_rdata[31:16];
      if (ack && state_r == res_pkg::S_RD_UEVT) used_event_r <= rd_half;
      if (ack && state_r == res_pkg::S_RD_ENT) begin
        head_r       <= rd_half;
        last_avail_r <= last_avail_r + 16'h0001;
      end
      if (ack && state_r == res_pkg::S_WR_UIDX) begin
        old_idx_r  <= used_idx_r;
        used_idx_r <= uidx_inc;
      end
    end
  end

  // Handshakes and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_pend_r   <= 1'b0;
      poll_pend_r  <= 1'b0;
      cmp_id_r     <= 16'h0000;
      cmp_len_r    <= 32'h0000_0000;
      done_ready_r <= 1'b0;
      head_valid_r <= 1'b0;
      desc_wr_r    <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      done_ready_r <= take_done;
      if (take_done) begin
        cmp_pend_r <= 1'b1;
        cmp_id_r   <= done_id;
        cmp_len_r  <= done_len;
      end else if (state_r == res_pkg::S_DECIDE) begin
        cmp_pend_r <= 1'b0;
      end
      poll_pend_r  <= poll_set | (poll_pend_r & ~poll_clr);
      if (ack && state_r == res_pkg::S_RD_ENT) begin
        head_valid_r <= 1'b1;
      end else if (head_ready) begin
        head_valid_r <= 1'b0;
      end
      desc_wr_r    <= desc_flags[res_pkg::DESC_WRITE_BIT] &
                      ~desc_flags[res_pkg::DESC_IND_BIT];
      irq_r        <= (state_r == res_pkg::S_DECIDE) & sif.need;
    end
  end

  // ----------------------------------------------------------------
  // Decision unit hookup
  // ----------------------------------------------------------------
  assign sif.evt         = evt;
  assign sif.suppress    = ctrl_r[res_pkg::CTRL_SUP_BIT];
  assign sif.avail_flags = avail_flags_r;
  assign sif.used_event  = used_event_r;
  assign sif.old_idx     = old_idx_r;
  assign sif.last_avail  = last_avail_r;

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign mem_req       = mreq_r;
  assign mem_we        = mwe_r;
  assign mem_addr      = maddr_r;
  assign mem_wdata     = mwdata_r;
  assign mem_be        = mbe_r;
  assign done_ready    = done_ready_r;
  assign head_valid    = head_valid_r;
  assign head_id       = head_r;
  assign desc_writable = desc_wr_r;
  assign irq           = irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_IND_NOWR: assert property (@(posedge pclk) disable iff (!presetn)
    desc_flags[2] |=> !desc_writable)
    else $error("indirect descriptor reported writable");
  AST_AVAIL_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    ack && state_r == res_pkg::S_RD_ENT && en |=> last_avail_r == $past(last_avail_r) + 16'h0001 ##0 head_valid)
    else $error("offered counter did not step");
  AST_CNT_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_clr |=> last_avail_r == 16'h0000 && used_idx_r == 16'h0000)
    else $error("counters not cleared when disabled");
  AST_ENT_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req && state_r == res_pkg::S_WR_ID |-> mem_addr == {u_id[31:2], 2'b00} && mem_be == 4'hF && mem_wdata[15:0] == cmp_id_r)
    else $error("entry head word misplaced");
  AST_IRQ_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> $past(state_r == res_pkg::S_DECIDE) && $past(old_idx_r + 16'h0001 == used_idx_r))
    else $error("interrupt before completed entry written");
  AST_FLAGS_EVT: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req && state_r == res_pkg::S_WR_UFLG && evt |-> mem_wdata[15:0] == 16'h0000)
    else $error("nonzero flags with event index");
  AST_UIDX_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    ack && state_r == res_pkg::S_WR_UIDX && $past(en) |=> used_idx_r == $past(used_idx_r) + 16'h0001)
    else $error("completion counter did not step");
  AST_SPURIOUS: assert property (@(posedge pclk) disable iff (!presetn)
    notify |=> poll_pend_r ##0 state_r != res_pkg::S_WR_ID || $past(cmp_pend_r) || cmp_pend_r)
    else $error("notification mishandled");

endmodule : res_core

/* File: verif/res_mem_model.sv */
// Memory model holding both rings, acking after a chosen delay
`timescale 1ns/100ps
module res_mem_model (
  input  wire logic        pclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [3:0]  mem_be,
  input  wire logic [1:0]  slow,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [0:255];
  logic [1:0]  wait_cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wait_cnt = 2'h0;
    for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  end
  always @(posedge pclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    wait_cnt <= 2'h0;
    if (mem_req && !mem_ack) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt >= slow) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr[9:2]];
        for (int i = 0; i < 4; i++)
          if (mem_we && mem_be[i]) mem[mem_addr[9:2]][8*i +: 8] <= mem_wdata[8*i +: 8];
      end
    end
  end
endmodule : res_mem_model

/* File: verif/testbench.sv */
// Self-checking bench for the ring event suppression block
`timescale 1ns/100ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, notify, done_valid, head_ready;
  logic pready, pslverr, mem_req, mem_we, mem_ack, done_ready, head_valid, desc_writable, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, done_len, rd, heads;
  logic [15:0] done_id, head_id, desc_flags, uidx, ue;
  logic [3:0]  mem_be;
  logic [1:0]  slow;
  logic        err;
  int          error_cnt, check_count, irq_cnt, seed;
  res_core u_res_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_ack,
    .mem_rdata, .notify, .done_valid, .done_id, .done_len, .done_ready, .head_valid,
    .head_id, .head_ready, .desc_flags, .desc_writable, .irq);
  res_mem_model u_res_mem_model (.pclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be,
    .slow, .mem_ack, .mem_rdata);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  always @(posedge pclk) if (head_valid === 1'b1 && head_ready === 1'b1) heads <= {heads[15:0], head_id};
  function automatic logic want(input logic evt, input logic [15:0] f, input logic [15:0] o);
    return evt ? (o == ue) : !f[0];
  endfunction : want
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic complete(input logic evt);
    logic [15:0] id, fl;
    logic [31:0] ln;
    int n0;
    id = 16'($random(seed));
    ln = $random(seed);
    n0 = irq_cnt;
    fl = u_res_mem_model.mem[8'h40][15:0];
    slow <= 2'($random(seed));
    notify <= 1'($random(seed));
    done_id <= id;
    done_len <= ln;
    done_valid <= 1'b1;
    do @(posedge pclk); while (done_ready !== 1'b1);
    done_valid <= 1'b0;
    notify <= 1'b0;
    repeat (80) @(posedge pclk);
    chk("id", {16'h0, id}, u_res_mem_model.mem[8'h81 + 2*uidx[1:0]]);
    chk("len", ln, u_res_mem_model.mem[8'h82 + 2*uidx[1:0]]);
    chk("irq", 32'(want(evt, fl, uidx)), 32'(irq_cnt - n0));
    uidx = uidx + 16'h1;
    chk("uidx", {16'h0, uidx}, {16'h0, u_res_mem_model.mem[8'h80][31:16]});
    chk("uflg", 32'h0, {31'h0, u_res_mem_model.mem[8'h80][15:1] != 0});
  endtask : complete
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    seed = 11171;
    {presetn, psel, penable, pwrite, notify, done_valid, head_ready} = 7'h0;
    {paddr, pwdata, done_id, done_len, desc_flags, slow, uidx, heads} = '0;
    {error_cnt, check_count, irq_cnt} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    head_ready <= 1'b1;
    apb(1'b0, res_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, res_pkg::REG_QSIZE, 32'h0);
    chk("qsize", 32'h0000_0100, rd);
    apb(1'b1, 12'h018, 32'hFFFF_FFFF);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, res_pkg::REG_QSIZE, 32'h4);
    apb(1'b1, res_pkg::REG_AVAIL_BASE, 32'h100);
    apb(1'b1, res_pkg::REG_USED_BASE, 32'h200);
    apb(1'b1, res_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      u_res_mem_model.mem[8'h40] = {16'h0, 15'h0, i[0]};
      complete(1'b0);
    end
    $display("legacy test done");
    apb(1'b1, res_pkg::REG_CTRL, 32'h3);
    ue = 16'h7;
    u_res_mem_model.mem[8'h43] = {16'h0, ue};
    u_res_mem_model.mem[8'h40] = 32'h1;
    for (int i = 0; i < 6; i++) complete(1'b1);
    $display("event test done");
    u_res_mem_model.mem[8'h41] = 32'h00B2_00A1;
    u_res_mem_model.mem[8'h40] = 32'h0002_0000;
    apb(1'b1, res_pkg::REG_CTRL, 32'hF);
    repeat (60) @(posedge pclk);
    chk("heads", 32'h00A1_00B2, heads);
    chk("aevt", 32'h0000_FFFF, {16'h0, u_res_mem_model.mem[8'h89][15:0]});
    apb(1'b0, res_pkg::REG_STATUS, 32'h0);
    chk("status", {uidx, 16'h0002}, rd);
    apb(1'b0, res_pkg::REG_SEEN, 32'h0);
    chk("seen", {ue, 16'h0002}, rd);
    apb(1'b1, res_pkg::REG_CTRL, 32'hD);
    repeat (40) @(posedge pclk);
    chk("uflg1", 32'h1, {16'h0, u_res_mem_model.mem[8'h80][15:0]});
    apb(1'b0, res_pkg::REG_CTRL, 32'h0);
    chk("ctrl2", 32'h5, rd);
    $display("fetch test done");
    for (int i = 0; i < 4; i++) begin
      desc_flags <= {13'h0, i[1:0], 1'b1};
      repeat (2) @(posedge pclk);
      chk("wrbl", {31'h0, i[0] & ~i[1]}, {31'h0, desc_writable});
    end
    $display("descriptor test done");
    tally_and_finish();
  end
endmodule : testbench
